/* hdl/register_file_transfer_unit.sv */
/*
  transfer unit between integer registers and the flag, branch, application, user
  mask, monitor, identification and float register views, plus an avalon-mm slave.
  assumes the pipeline owns the integer and float files and writes back the result.
*/
`timescale 1ns/1ns
module register_file_transfer_unit (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          srst,
  // issue side
  input  wire logic          req_valid,
  input  xfer_pkg::op_e      req_op,
  input  xfer_pkg::cls_e     req_cls,
  input  wire logic [3:0]    req_idx,
  input  wire logic [23:0]   req_imm,
  input  wire logic [63:0]   req_gr,
  input  wire logic          req_gr_nat,
  input  wire logic [81:0]   req_fr,
  input  wire logic [63:0]   req_ip,
  // write-back side
  output logic               rsp_valid,
  output logic [63:0]        rsp_gr,
  output logic               rsp_gr_nat,
  output logic               rsp_gr_we,
  output logic [81:0]        rsp_fr,
  output logic               rsp_fr_we,
  output logic               rsp_illegal,
  output logic               hint_valid,
  output logic [2:0]         hint,
  // avalon-mm slave
  input  wire logic [4:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [3:0]    avs_byteenable,
  input  wire logic [31:0]   avs_writedata,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest
);
  import xfer_pkg::*;

  typedef struct packed {
    logic [63:0]                flags;
    logic [NUM_BR-1:0][63:0]    jump_target_regs;
    logic [NUM_BR-1:0][2:0]     jump_hints;
    logic [NUM_AR-1:0][63:0]    appl_regs;
    logic [NUM_PMD-1:0][63:0]   pmd;
    logic [63:0]                state_word;
    logic                       pmd_user_en;
    logic                       ack;
    logic [31:0]                rdata;
    logic                       rv;
    logic [63:0]                rgr;
    logic                       rnat;
    logic                       rgr_we;
    logic [81:0]                rfr;
    logic                       rfr_we;
    logic                       rill;
    logic                       hv;
    logic [2:0]                 hint;
  } xfer_s;

  xfer_s       st_r;
  xfer_s       st_nxt;
  logic [81:0] cv_fr;
  logic [63:0] cv_gr;
  logic        cv_nat;
  logic        bus_req;
  logic [63:0] fm;

  fr_convert u_conv (
    .op         (req_op),
    .gr_in      (req_gr),
    .gr_nat_in  (req_gr_nat),
    .fr_in      (req_fr),
    .fr_out     (cv_fr),
    .gr_out     (cv_gr),
    .gr_nat_out (cv_nat)
  );

  assign bus_req = avs_read | avs_write;
  // one wait cycle lets readdata come from a flop
  assign avs_waitrequest = bus_req & ~st_r.ack;
  assign avs_readdata = st_r.rdata;
  assign rsp_valid = st_r.rv;
  assign rsp_gr = st_r.rgr;
  assign rsp_gr_nat = st_r.rnat;
  assign rsp_gr_we = st_r.rgr_we;
  assign rsp_fr = st_r.rfr;
  assign rsp_fr_we = st_r.rfr_we;
  assign rsp_illegal = st_r.rill;
  assign hint_valid = st_r.hv;
  assign hint = st_r.hint;
  assign fm = flag_mask(req_imm[16:0]);

  always_comb begin
    st_nxt = st_r;
    st_nxt.rv = 1'b0;
    st_nxt.rgr = '0;
    st_nxt.rnat = 1'b0;
    st_nxt.rgr_we = 1'b0;
    st_nxt.rfr = '0;
    st_nxt.rfr_we = 1'b0;
    st_nxt.rill = 1'b0;
    st_nxt.hv = 1'b0;
    st_nxt.hint = '0;
    st_nxt.pmd[1] = st_r.pmd[1] + 64'h1;
    // state written here is visible to the very next request
    if (req_valid) begin
      st_nxt.rv = 1'b1;
      st_nxt.pmd[0] = st_r.pmd[0] + 64'h1;
      case (req_op)
        OP_GETF_EXP, OP_GETF_SIG, OP_GETF_S, OP_GETF_D: begin
          st_nxt.rgr = cv_gr;
          st_nxt.rnat = cv_nat;
          st_nxt.rgr_we = 1'b1;
        end
        OP_SETF_EXP, OP_SETF_SIG, OP_SETF_S, OP_SETF_D: begin
          st_nxt.rfr = cv_fr;
          st_nxt.rfr_we = 1'b1;
        end
        OP_MOV_TO: begin
          case (req_cls)
            CLS_BR: begin
              st_nxt.jump_target_regs[req_idx[2:0]] = req_gr;
              st_nxt.jump_hints[req_idx[2:0]] = req_imm[2:0];
              st_nxt.hv = 1'b1;
              st_nxt.hint = req_imm[2:0];
            end
            CLS_FLAG: begin
              // physical bit n, rotation base taken as zero
              st_nxt.flags = (st_r.flags & ~fm) | (req_gr & fm);
              st_nxt.flags[0] = 1'b1;
            end
            CLS_AR: st_nxt.appl_regs[req_idx[2:0]] = req_gr;
            CLS_UM: begin
              st_nxt.state_word = (st_r.state_word & ~UM_BITS) |
                                  (req_gr & UM_BITS);
            end
            default: st_nxt.rill = 1'b1;
          endcase
        end
        OP_TO_FLAG_ROT: begin
          st_nxt.flags = (st_r.flags & ~flag_mask(17'h10000)) |
                         (req_gr & flag_mask(17'h10000));
          st_nxt.flags[0] = 1'b1;
        end
        OP_MOV_FROM: begin
          st_nxt.rgr_we = 1'b1;
          case (req_cls)
            CLS_BR: st_nxt.rgr = st_r.jump_target_regs[req_idx[2:0]];
            CLS_FLAG: st_nxt.rgr = st_r.flags;
            CLS_AR: st_nxt.rgr = st_r.appl_regs[req_idx[2:0]];
            CLS_UM: st_nxt.rgr = st_r.state_word & UM_BITS;
            CLS_PMD: begin
              st_nxt.rgr = st_r.pmd_user_en ? st_r.pmd[req_idx[0]] : 64'h0;
            end
            CLS_CPUID: st_nxt.rgr = req_idx[0] ? CPUID1 : CPUID0;
            CLS_IP: st_nxt.rgr = req_ip;
            default: begin
              st_nxt.rgr_we = 1'b0;
              st_nxt.rill = 1'b1;
            end
          endcase
        end
        OP_SET_UM: begin
          st_nxt.state_word = st_r.state_word |
                              ({40'h0, req_imm} & UM_BITS);
        end
        OP_RESET_UM: begin
          st_nxt.state_word = st_r.state_word &
                              ~({40'h0, req_imm} & UM_BITS);
        end
        OP_MEM: begin
          // other files must be staged through an integer register first
          st_nxt.rill = (req_cls != CLS_GR) && (req_cls != CLS_FR);
        end
        default: st_nxt.rv = 1'b0;
      endcase
    end
    // avalon slave: answer one cycle after the request appears
    st_nxt.ack = bus_req & ~st_r.ack;
    if (bus_req && !st_r.ack) begin
      case (avs_address)
        OFS_CTRL: st_nxt.rdata = {31'h0, st_r.pmd_user_en};
        OFS_STATE: st_nxt.rdata = st_r.state_word[31:0];
        OFS_FLAG_LO: st_nxt.rdata = st_r.flags[31:0];
        OFS_FLAG_HI: st_nxt.rdata = st_r.flags[63:32];
        OFS_COUNT: st_nxt.rdata = st_r.pmd[0][31:0];
        default: st_nxt.rdata = 32'h0;
      endcase
    end
    if (avs_write && st_r.ack && avs_address == OFS_CTRL && avs_byteenable[0]) begin
      st_nxt.pmd_user_en = avs_writedata[CTRL_PMD_EN];
    end
    if (srst) begin
      st_nxt = '0;
      st_nxt.flags = FLAG_RESET;
      st_nxt.pmd_user_en = CTRL_RESET;
    end
  end

  always_ff @(posedge core_clk) begin
    st_r <= st_nxt;
  end

  // checks
  flag_zero_a: assert property (@(posedge core_clk) disable iff (srst)
    st_r.flags[0]) else $error("flag zero cleared");

  flag_keep_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_op == OP_MOV_TO && req_cls == CLS_FLAG
    |=> (st_r.flags & ~$past(fm)) == ($past(st_r.flags) & ~$past(fm)))
    else $error("unmasked flag changed");

  flag_load_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_op == OP_MOV_TO && req_cls == CLS_FLAG ##1 !req_valid
    ##1 req_valid && req_op == OP_MOV_FROM && req_cls == CLS_FLAG
    |=> rsp_gr == (($past(req_gr, 3) & $past(fm, 3)) |
                   ($past(st_r.flags, 3) & ~$past(fm, 3))))
    else $error("flag write not seen");

  rot_keep_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_op == OP_TO_FLAG_ROT
    |=> st_r.flags[15:0] == $past(st_r.flags[15:0]))
    else $error("static flags moved by rotating write");

  flag_read_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_op == OP_MOV_FROM && req_cls == CLS_FLAG
    |=> rsp_gr_we && rsp_gr == $past(st_r.flags))
    else $error("flag bank read wrong");

  hint_pulse_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_op == OP_MOV_TO && req_cls == CLS_BR
    |=> hint_valid && hint == $past(req_imm[2:0]))
    else $error("branch hint lost");

  pmd_gate_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_op == OP_MOV_FROM && req_cls == CLS_PMD && !st_r.pmd_user_en
    |=> rsp_gr == 64'h0 && rsp_gr_we) else $error("monitor read leaked");

  id_ro_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_op == OP_MOV_TO && req_cls == CLS_CPUID
    |=> rsp_illegal && !rsp_gr_we)
    else $error("identification register written");

  sig_canon_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_op == OP_SETF_SIG && !req_gr_nat
    |=> rsp_fr_we && rsp_fr[FR_EXP_HI:FR_EXP_LO] == EXP_INT && !rsp_fr[FR_SIGN]
        && rsp_fr[63:0] == $past(req_gr)) else $error("integer not canonical");

  exp_move_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_op == OP_SETF_EXP && !req_gr_nat
    |=> rsp_fr[81:64] == $past(req_gr[17:0]) && rsp_fr[63:0] == SIG_INT_BIT)
    else $error("exponent move wrong");

  sig_get_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_op == OP_GETF_SIG && req_fr != NATVAL
    |=> rsp_gr_we && rsp_gr == $past(req_fr[63:0]))
    else $error("significand move wrong");

  single_exp_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_op == OP_SETF_S && !req_gr_nat && req_gr[30:23] != 8'h00
    && req_gr[30:23] != 8'hFF
    |=> rsp_fr[80:64] == EXP_S_OFF + {9'h000, $past(req_gr[30:23])} && rsp_fr[63])
    else $error("single exponent not rebiased");

  double_exp_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_op == OP_SETF_D && !req_gr_nat && req_gr[62:52] != 11'h000
    && req_gr[62:52] != 11'h7FF
    |=> rsp_fr[80:64] == EXP_D_OFF + {6'h00, $past(req_gr[62:52])} && rsp_fr[63])
    else $error("double exponent not rebiased");

  nat_conv_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_gr_nat && (req_op == OP_SETF_S || req_op == OP_SETF_D)
    |=> rsp_fr == NATVAL) else $error("token not converted");

  nat_out_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_fr == NATVAL && (req_op == OP_GETF_SIG || req_op == OP_GETF_D)
    |=> rsp_gr_nat && rsp_gr == 64'h0)
    else $error("token not raised");

  mem_file_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_op == OP_MEM
    |=> rsp_illegal == !($past(req_cls) == CLS_GR || $past(req_cls) == CLS_FR))
    else $error("memory file check wrong");

  bad_quiet_a: assert property (@(posedge core_clk) disable iff (srst)
    rsp_illegal |-> !rsp_gr_we && !rsp_fr_we && !hint_valid)
    else $error("write enable with illegal class");

  um_set_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_op == OP_SET_UM
    |=> (st_r.state_word[5:0] & $past(req_imm[5:0])) == $past(req_imm[5:0]))
    else $error("user mask bits not set");

  um_clear_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_op == OP_RESET_UM
    |=> (st_r.state_word[5:0] & $past(req_imm[5:0])) == 6'h00)
    else $error("user mask bits not cleared");

  um_only_a: assert property (@(posedge core_clk) disable iff (srst)
    ##1 (st_r.state_word & ~UM_BITS) == ($past(st_r.state_word) & ~UM_BITS))
    else $error("privileged state bits moved");

  ip_copy_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_op == OP_MOV_FROM && req_cls == CLS_IP
    |=> rsp_gr == $past(req_ip) && rsp_gr_we) else $error("pointer copy wrong");

  nop_quiet_a: assert property (@(posedge core_clk) disable iff (srst)
    req_valid && req_op == OP_NOP |=> !rsp_valid)
    else $error("empty request answered");

  bus_answer_a: assert property (@(posedge core_clk) disable iff (srst)
    bus_req && avs_waitrequest |=> !avs_waitrequest) else $error("bus answer late");
endmodule

/* hdl/xfer_pkg.sv */
/*
  constants, types and helpers shared by the register-file transfer unit.
  assumes one 10 MHz core clock and a synchronous active-high reset.
*/
// Notes on behaviour
// - operand class, not opcode, picks the file
// - memory ops reach only integer/float files
// - significand and sign/exponent moves both ways
// - whole single/double moves with format conversion
// - deferred-exception tokens converted across files
// - branch writes take hints; reads copy out
// - flag N maps to integer bit N
// - mask: bits 1-15 static, one rotating bit
// - flag 0 reads one, never written
// - flag written only where mask bit set
// - rotation base ignored, treated as zero
// - flag read copies whole bank
// - user mask copy, set and clear
// - user mask is unprivileged state subset
// - monitor read zero unless user enabled
// - read-only identification register copy
// - fetch pointer copied to integer reg
// - float reg 82 bits: sign, exp17, sig64
// - integer into float: canonical exp, sign 0
package xfer_pkg;
  localparam int GR_W = 64;
  localparam int FR_W = 82;
  localparam int NUM_BR = 8;
  localparam int NUM_AR = 8;
  localparam int NUM_PMD = 2;
  localparam int FR_SIGN = 81;
  localparam int FR_EXP_HI = 80;
  localparam int FR_EXP_LO = 64;
  localparam logic [16:0] EXP_INT = 17'h1003E;
  localparam logic [16:0] EXP_SPECIAL = 17'h1FFFF;
  localparam logic [16:0] EXP_S_OFF = 17'h0FF80;
  localparam logic [16:0] EXP_D_OFF = 17'h0FC00;
  localparam logic [10:0] EMAX_S = 11'h0FF;
  localparam logic [10:0] EMAX_D = 11'h7FF;
  localparam logic [63:0] SIG_INT_BIT = 64'h8000000000000000;
  // token value for a deferred exception held in a float register
  localparam logic [81:0] NATVAL = {1'b0, 17'h1FFFE, 64'h0};
  localparam logic [63:0] UM_BITS = 64'h000000000000003F;
  // identification words: arbitrary values
  localparam logic [63:0] CPUID0 = 64'h0000000012345678;
  localparam logic [63:0] CPUID1 = 64'h0000000000000001;
  // avalon byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATE = 5'h04;
  localparam logic [4:0] OFS_FLAG_LO = 5'h08;
  localparam logic [4:0] OFS_FLAG_HI = 5'h0C;
  localparam logic [4:0] OFS_COUNT = 5'h10;
  localparam int CTRL_PMD_EN = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [63:0] FLAG_RESET = 64'h0000000000000001;

  typedef enum logic [3:0] {
    OP_NOP, OP_GETF_EXP, OP_GETF_SIG, OP_GETF_S, OP_GETF_D,
    OP_SETF_EXP, OP_SETF_SIG, OP_SETF_S, OP_SETF_D,
    OP_MOV_TO, OP_MOV_FROM, OP_TO_FLAG_ROT, OP_SET_UM, OP_RESET_UM, OP_MEM
  } op_e;

  typedef enum logic [3:0] {
    CLS_GR, CLS_FR, CLS_BR, CLS_FLAG, CLS_AR, CLS_UM, CLS_PMD, CLS_CPUID, CLS_IP
  } cls_e;

  function automatic logic [63:0] flag_mask(input logic [16:0] imm);
    flag_mask = {{48{imm[16]}}, imm[15:1], 1'b0};
  endfunction

  function automatic logic is_natval(input logic [81:0] fr);
    is_natval = (fr == NATVAL);
  endfunction
endpackage

/* hdl/fr_convert.sv */
/*
  combinational conversion between integer words and 82-bit float register values.
  assumes the caller registers the outputs; exponents outside the memory range are not
  rounded or trapped.
*/
`timescale 1ns/1ns
module fr_convert (
  // request
  input  xfer_pkg::op_e    op,
  input  wire logic [63:0] gr_in,
  input  wire logic        gr_nat_in,
  input  wire logic [81:0] fr_in,
  // result
  output logic      [81:0] fr_out,
  output logic      [63:0] gr_out,
  output logic             gr_nat_out
);
  import xfer_pkg::*;

  function automatic logic [81:0] to_reg(input logic s, input logic [10:0] e,
      input logic [51:0] f, input logic [10:0] emax, input logic [16:0] off);
    if (e == emax) begin
      to_reg = {s, EXP_SPECIAL, 1'b1, f, 11'h000};
    end else if (e == 11'h000 && f == 52'h0) begin
      to_reg = {s, 17'h00000, 64'h0};
    end else if (e == 11'h000) begin
      to_reg = {s, off + 17'h00001, 1'b0, f, 11'h000};
    end else begin
      to_reg = {s, off + {6'h00, e}, 1'b1, f, 11'h000};
    end
  endfunction

  function automatic logic [63:0] to_mem(input logic [81:0] fr, input logic [16:0] off,
      input logic [10:0] emax, input logic dbl);
    logic [16:0] d;
    logic [10:0] e;
    d = fr[80:64] - off;
    if (fr[80:64] == EXP_SPECIAL) begin
      e = emax;
    end else if (fr[80:64] == 17'h00000 || !fr[63]) begin
      e = 11'h000;
    end else begin
      e = d[10:0];
    end
    if (dbl) begin
      to_mem = {fr[81], e, fr[62:11]};
    end else begin
      to_mem = {32'h0, fr[81], e[7:0], fr[62:40]};
    end
  endfunction

  always_comb begin
    fr_out = '0;
    gr_out = '0;
    gr_nat_out = 1'b0;
    case (op)
      OP_SETF_SIG: fr_out = {1'b0, EXP_INT, gr_in};
      OP_SETF_EXP: fr_out = {gr_in[17], gr_in[16:0], SIG_INT_BIT};
      OP_SETF_S: fr_out = to_reg(gr_in[31], {3'h0, gr_in[30:23]},
                                 {gr_in[22:0], 29'h0}, EMAX_S, EXP_S_OFF);
      OP_SETF_D: fr_out = to_reg(gr_in[63], gr_in[62:52], gr_in[51:0],
                                 EMAX_D, EXP_D_OFF);
      OP_GETF_SIG: gr_out = fr_in[63:0];
      OP_GETF_EXP: gr_out = {46'h0, fr_in[81:64]};
      OP_GETF_S: gr_out = to_mem(fr_in, EXP_S_OFF, EMAX_S, 1'b0);
      OP_GETF_D: gr_out = to_mem(fr_in, EXP_D_OFF, EMAX_D, 1'b1);
      default: gr_out = '0;
    endcase
    // tokens override whatever the value path produced
    if (gr_nat_in && (op == OP_SETF_SIG || op == OP_SETF_EXP ||
                      op == OP_SETF_S || op == OP_SETF_D)) begin
      fr_out = NATVAL;
    end
    if (is_natval(fr_in) && (op == OP_GETF_SIG || op == OP_GETF_EXP ||
                             op == OP_GETF_S || op == OP_GETF_D)) begin
      gr_out = '0;
      gr_nat_out = 1'b1;
    end
  end
endmodule

/* bench/pipe_model.sv */
/*
  issuing pipeline stand-in: sends one transfer request at a time.
  assumes its caller waits for reset release before the first issue.
*/
`timescale 1ns/1ns
module pipe_model (
  // clock
  input  wire logic      core_clk,
  // issue side
  output logic           req_valid,
  output xfer_pkg::op_e  req_op,
  output xfer_pkg::cls_e req_cls,
  output logic [3:0]     req_idx,
  output logic [23:0]    req_imm,
  output logic [63:0]    req_gr,
  output logic           req_gr_nat,
  output logic [81:0]    req_fr,
  output logic [63:0]    req_ip
);
  import xfer_pkg::*;
  int sent = 0;
  initial begin
    req_valid  = 1'b0;
    req_op     = OP_NOP;
    req_cls    = CLS_GR;
    req_idx    = 4'h0;
    req_imm    = 24'h000000;
    req_gr     = 64'h0;
    req_gr_nat = 1'b0;
    req_fr     = 82'h0;
    req_ip     = 64'h0;
  end
  // memory ops name only integer or float operands; others go via integer regs
  task automatic issue(input op_e op, input cls_e cls, input logic [3:0] idx,
                       input logic [23:0] imm, input logic [63:0] gr,
                       input logic nat, input logic [81:0] fr);
    @(posedge core_clk);
    req_valid  <= 1'b1;
    req_op     <= op;
    req_cls    <= cls;
    req_idx    <= idx;
    req_imm    <= imm;
    req_gr     <= gr;
    req_gr_nat <= nat;
    req_fr     <= fr;
    req_ip     <= gr;
    sent++;
    @(posedge core_clk);
    req_valid  <= 1'b0;
    // idle lines flip so a stale operand cannot pass for a live one
    req_gr     <= ~gr;
    req_fr     <= ~fr;
    req_ip     <= ~gr;
    req_imm    <= ~imm;
    #1;
  endtask
endmodule

/* bench/testbench.sv */
/*
  self-checking bench for the transfer unit: reference model in integers.
  assumes a 10 MHz core clock and the one-wait-cycle avalon slave.
*/
`timescale 1ns/1ns
module testbench;
  import xfer_pkg::*;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        req_valid, req_gr_nat, rsp_valid, rsp_gr_nat, rsp_gr_we, rsp_fr_we;
  logic        rsp_illegal, hint_valid, avs_read, avs_write, avs_waitrequest;
  op_e         req_op;
  cls_e        req_cls;
  logic [3:0]  req_idx, avs_byteenable;
  logic [23:0] req_imm, mk;
  logic [63:0] req_gr, req_ip, rsp_gr, bank_m, v;
  logic [81:0] req_fr, rsp_fr, f;
  logic [2:0]  hint;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, w;
  logic [5:0]  um_m;
  int          bad_count = 0, comparisons = 0, k;

  always #50 core_clk = ~core_clk;

  pipe_model pm_u (.core_clk, .req_valid, .req_op, .req_cls, .req_idx, .req_imm,
                   .req_gr, .req_gr_nat, .req_fr, .req_ip);
  register_file_transfer_unit dut_u (.core_clk, .srst, .req_valid, .req_op, .req_cls,
    .req_idx, .req_imm, .req_gr, .req_gr_nat, .req_fr, .req_ip, .rsp_valid, .rsp_gr,
    .rsp_gr_nat, .rsp_gr_we, .rsp_fr, .rsp_fr_we, .rsp_illegal, .hint_valid, .hint,
    .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
    .avs_readdata, .avs_waitrequest);

  task automatic complete_run;
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk_int(input string n, input logic [63:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_float(input string n, input logic [81:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_word(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  // held until the edge at which waitrequest is sampled low; the watchdog ends a hang
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic iss(input op_e op, input cls_e c, input logic [3:0] i,
                     input logic [23:0] m, input logic [63:0] g, input logic [81:0] fv);
    pm_u.issue(op, c, i, m, g, 1'b0, fv);
    chk_bit("rsp_valid", 1'b1, rsp_valid);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    complete_run();
  end

  initial begin
    avs_address    = 5'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_byteenable = 4'hF;
    avs_writedata  = 32'h00000000;
    k = $urandom(29036);
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    bank_m = FLAG_RESET;
    iss(OP_MOV_FROM, CLS_FLAG, 4'h0, 24'h0, 64'h0, 82'h0);
    chk_int("flags", bank_m, rsp_gr);
    // full mask, empty mask, then random masks
    for (k = 0; k < 14; k++) begin
      v = {$urandom, $urandom};
      mk = (k == 0) ? 24'h01FFFF : (k == 1) ? 24'h000000 : $urandom & 24'h01FFFF;
      for (int n = 1; n < 64; n++) if (mk[(n < 16) ? n : 16]) bank_m[n] = v[n];
      iss(OP_MOV_TO, CLS_FLAG, 4'h0, mk, v, 82'h0);
      iss(OP_MOV_FROM, CLS_FLAG, 4'h0, 24'h0, 64'h0, 82'h0);
      chk_int("flags", bank_m, rsp_gr);
    end
    v = {$urandom, $urandom};
    bank_m[63:16] = v[63:16];
    iss(OP_TO_FLAG_ROT, CLS_FLAG, 4'h0, 24'h0, v, 82'h0);
    iss(OP_MOV_FROM, CLS_FLAG, 4'h0, 24'h0, 64'h0, 82'h0);
    chk_int("rotating", bank_m, rsp_gr);
    bus(1'b0, OFS_FLAG_LO, 32'h0, w);
    chk_word("flag_lo", bank_m[31:0], w);
    bus(1'b0, OFS_FLAG_HI, 32'h0, w);
    chk_word("flag_hi", bank_m[63:32], w);
    bus(1'b0, 5'h14, 32'h0, w);
    chk_word("unmapped", 32'h00000000, w);
    iss(OP_MOV_FROM, CLS_IP, 4'h0, 24'h0, v, 82'h0);
    chk_int("ip", v, rsp_gr);
    iss(OP_SETF_SIG, CLS_FR, 4'h0, 24'h0, v, 82'h0);
    chk_float("setf_sig", {1'b0, EXP_INT, v}, rsp_fr);
    f = {$urandom, $urandom, $urandom};
    iss(OP_GETF_SIG, CLS_FR, 4'h0, 24'h0, 64'h0, f);
    chk_int("getf_sig", f[63:0], rsp_gr);
    iss(OP_GETF_EXP, CLS_FR, 4'h0, 24'h0, 64'h0, f);
    chk_int("getf_exp", {46'h0, f[81], f[80:64]}, rsp_gr);
    iss(OP_SETF_EXP, CLS_FR, 4'h0, 24'h0, v, 82'h0);
    chk_float("setf_exp", {v[17], v[16:0], SIG_INT_BIT}, rsp_fr);
    // single pi: exponent 0x80 rebiased by 65535-127
    iss(OP_SETF_S, CLS_FR, 4'h0, 24'h0, 64'h40490FDB, 82'h0);
    chk_float("setf_s", {1'b0, 17'h10000, 64'hC90FDB0000000000}, rsp_fr);
    iss(OP_GETF_S, CLS_FR, 4'h0, 24'h0, 64'h0, {1'b0, 17'h10000, 64'hC90FDB0000000000});
    chk_int("getf_s", 64'h0000000040490FDB, rsp_gr);
    iss(OP_SETF_D, CLS_FR, 4'h0, 24'h0, 64'hC000000000000000, 82'h0);
    chk_float("setf_d", {1'b1, 17'h10000, SIG_INT_BIT}, rsp_fr);
    iss(OP_GETF_D, CLS_FR, 4'h0, 24'h0, 64'h0, {1'b1, 17'h10000, SIG_INT_BIT});
    chk_int("getf_d", 64'hC000000000000000, rsp_gr);
    pm_u.issue(OP_SETF_D, CLS_FR, 4'h0, 24'h0, v, 1'b1, 82'h0);
    chk_float("token_in", NATVAL, rsp_fr);
    pm_u.issue(OP_GETF_SIG, CLS_FR, 4'h0, 24'h0, 64'h0, 1'b0, NATVAL);
    chk_bit("token_out", 1'b1, rsp_gr_nat);
    // writing the other file between shows the operand picks the target
    for (k = 0; k < 8; k++) begin
      v = {$urandom, $urandom};
      iss(OP_MOV_TO, CLS_BR, k[3:0], {21'h0, k[2:0]}, v, 82'h0);
      chk_bit("hint_valid", 1'b1, hint_valid);
      chk_int("hint", {61'h0, k[2:0]}, {61'h0, hint});
      iss(OP_MOV_TO, CLS_AR, k[3:0], 24'h0, ~v, 82'h0);
      iss(OP_MOV_FROM, CLS_BR, k[3:0], 24'h0, 64'h0, 82'h0);
      chk_int("branch", v, rsp_gr);
      iss(OP_MOV_FROM, CLS_AR, k[3:0], 24'h0, 64'h0, 82'h0);
      chk_int("appl", ~v, rsp_gr);
    end
    v = {$urandom, $urandom};
    mk = $urandom;
    um_m = (v[5:0] | mk[5:0]) & ~mk[11:6];
    iss(OP_MOV_TO, CLS_UM, 4'h0, 24'h0, v, 82'h0);
    iss(OP_SET_UM, CLS_UM, 4'h0, mk, 64'h0, 82'h0);
    iss(OP_RESET_UM, CLS_UM, 4'h0, {18'h0, mk[11:6]}, 64'h0, 82'h0);
    iss(OP_MOV_FROM, CLS_UM, 4'h0, 24'h0, 64'h0, 82'h0);
    chk_int("user_mask", {58'h0, um_m}, rsp_gr);
    bus(1'b0, OFS_STATE, 32'h0, w);
    chk_word("state", {26'h0, um_m}, w & 32'h0000003F);
    iss(OP_MOV_FROM, CLS_PMD, 4'h1, 24'h0, 64'h0, 82'h0);
    chk_int("pmd_off", 64'h0, rsp_gr);
    bus(1'b1, OFS_CTRL, 32'h00000001, w);
    bus(1'b0, OFS_CTRL, 32'h0, w);
    chk_word("ctrl", 32'h00000001, w);
    iss(OP_MOV_FROM, CLS_PMD, 4'h1, 24'h0, 64'h0, 82'h0);
    chk_bit("pmd_on", 1'b1, rsp_gr != 64'h0);
    iss(OP_MOV_FROM, CLS_CPUID, 4'h0, 24'h0, 64'h0, 82'h0);
    chk_int("cpuid0", CPUID0, rsp_gr);
    iss(OP_MOV_FROM, CLS_CPUID, 4'h1, 24'h0, 64'h0, 82'h0);
    chk_int("cpuid1", CPUID1, rsp_gr);
    // memory op with every class: only integer and float are legal
    for (k = 0; k < 9; k++) begin
      iss(OP_MEM, cls_e'(k), 4'h0, 24'h0, 64'h0, 82'h0);
      chk_bit("illegal", k > 1, rsp_illegal);
    end
    pm_u.issue(OP_MOV_TO, CLS_CPUID, 4'h0, 24'h0, 64'h0, 1'b0, 82'h0);
    chk_bit("cpuid_ro", 1'b1, rsp_illegal);
    pm_u.issue(OP_NOP, CLS_GR, 4'h0, 24'h0, 64'h0, 1'b0, 82'h0);
    chk_bit("nop_valid", 1'b0, rsp_valid);
    bus(1'b0, OFS_COUNT, 32'h0, w);
    chk_word("count", pm_u.sent[31:0], w);
    complete_run();
  end
endmodule
